// file: rtl/rip_i2c_target.sv
// Notes on behaviour
// [R1] Target only; controller makes SCL, START and STOP; we never drive SCL.
// [R2] Works at 100 kHz and 400 kHz bus rates.
// [R3] Acknowledges only target address 0110010, ignores any other.
// [R4] Address byte LSB is direction: 65h read, 64h write.
// [R5] First byte after write address loads the register pointer.
// [R6] Acknowledge address, register address and every written data byte; store at pointer.
// [R7] Pointer advances by one after every data byte, either direction.
// [R8] Write address, repeated START, read address: data starts at that register.
// [R9] Controller ACK requests next byte from incremented address.
// [R10] Controller ends read with NACK then STOP.
// [R11] Read without register address starts after previously accessed register.
// [R12] Pointer wraps 0F to 00 and 1F to 10.
// [R13] SDA driven open-drain only; both lines read as open-drain inputs.
// [R14] Software reset bit acts at next STOP only, then self-clears.
// [R15] STOP releases SDA and idles anywhere; any START resynchronises.
`timescale 1ns/1ps
`default_nettype none

module rip_i2c_target
    import rip_pkg::*;
(
    input  wire logic                      i_sys_clk,
    input  wire logic                      i_rst_n,
    input  wire logic                      i_scl,
    input  wire logic                      i_sda,
    output var  logic                      o_sda_o,
    output var  logic                      o_sda_oe_n,
    output var  logic [rip_pkg::PTR_W-1:0] o_reg_addr,
    output var  logic                      o_reg_wr,
    output var  logic [7:0]                o_reg_wdata,
    output var  logic                      o_reg_rd,
    input  wire logic [7:0]                i_reg_rdata,
    output var  logic                      o_soft_rst
);
    import rip_pkg::*;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_ADDR = 6'h02,
        ST_RX   = 6'h04,
        ST_ACK  = 6'h08,
        ST_TX   = 6'h10,
        ST_RACK = 6'h20
    } rip_state_t;

    // ======================================================================
    // pointer arithmetic
    // ======================================================================
    // bank bit is kept, only the low nibble rolls over
    function automatic logic [PTR_W-1:0] ptr_next(input logic [PTR_W-1:0] p);
        ptr_next = {p[BANK_BIT_POS], p[3:0] + 4'h1};  // [R12]
    endfunction

    // ======================================================================
    // line sampling and bus events
    // ======================================================================
    logic [1:0] lines_s;
    logic       scl_s;
    logic       sda_s;
    logic       scl_p_q;
    logic       sda_p_q;

    // both lines are plain open-drain inputs from another domain [R13] [R2]
    rip_sync2 #(
        .W       (2),
        .RST_VAL (2'h3)
    ) u_sync (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (i_rst_n),
        .i_d       ({i_scl, i_sda}),
        .o_q       (lines_s)
    );

    assign scl_s = lines_s[1];
    assign sda_s = lines_s[0];

    // previous synced levels for edge finding
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;

    // both lines pass equal delay, so SDA-vs-SCL ordering is preserved
    assign scl_rise = scl_s & ~scl_p_q;
    assign scl_fall = ~scl_s & scl_p_q;
    assign start_ev = scl_s & scl_p_q & sda_p_q & ~sda_s;  // [R1]
    assign stop_ev  = scl_s & scl_p_q & ~sda_p_q & sda_s;  // [R1]

    // ======================================================================
    // byte engine
    // ======================================================================
    rip_state_t       state_q;
    logic [3:0]       cnt_q;
    logic [7:0]       rx_q;
    logic             rw_q;
    logic             first_q;
    logic [PTR_W-1:0] ptr_q;
    logic [7:0]       tx_q;
    logic [7:0]       rbuf_q;
    logic             rdreq_q;
    logic             oe_n_q;
    logic             arm_q;
    logic             byte_end;
    logic             addr_hit;

    assign byte_end = scl_fall && (cnt_q == BITS_PER_BYTE);
    assign addr_hit = (rx_q[7:1] == TARGET_ADDR);  // [R3]

    // state, bit count and transfer direction
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            state_q <= ST_IDLE;
            cnt_q   <= CNT_RST;
            rw_q    <= 1'b0;
            first_q <= 1'b0;
        end else if (start_ev) begin
            state_q <= ST_ADDR;  // [R15] start or restart resyncs
            cnt_q   <= CNT_RST;
        end else if (stop_ev) begin
            state_q <= ST_IDLE;  // [R15]
            cnt_q   <= CNT_RST;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    cnt_q <= CNT_RST;
                end
                ST_ADDR: begin
                    if (scl_rise) begin
                        cnt_q <= cnt_q + 4'h1;
                    end else if (byte_end) begin
                        if (addr_hit) begin
                            state_q <= ST_ACK;
                            rw_q    <= rx_q[RW_BIT_POS];                 // [R4]
                            first_q <= (rx_q[RW_BIT_POS] != RW_READ);    // [R5]
                        end else begin
                            state_q <= ST_IDLE;                          // [R3]
                        end
                    end
                end
                ST_RX: begin
                    if (scl_rise) begin
                        cnt_q <= cnt_q + 4'h1;
                    end else if (byte_end) begin
                        state_q <= ST_ACK;  // [R6]
                        first_q <= 1'b0;
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        state_q <= (rw_q == RW_READ) ? ST_TX : ST_RX;
                        cnt_q   <= CNT_RST;
                    end
                end
                ST_TX: begin
                    if (scl_rise) begin
                        cnt_q <= cnt_q + 4'h1;
                    end else if (byte_end) begin
                        state_q <= ST_RACK;
                    end
                end
                ST_RACK: begin
                    if (scl_rise && sda_s) begin
                        state_q <= ST_IDLE;  // controller nack ends the read
                    end else if (scl_fall) begin
                        state_q <= ST_TX;    // [R9]
                        cnt_q   <= CNT_RST;
                    end
                end
            endcase
        end
    end

    // receive shifter, sampled on SCL rising edges
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            rx_q <= BYTE_RST;
        end else if (scl_rise && (state_q == ST_ADDR || state_q == ST_RX)) begin
            rx_q <= {rx_q[6:0], sda_s};
        end
    end

    // ======================================================================
    // register pointer and register-side strobes
    // ======================================================================
    // pointer always names the next register to touch, so a read with no
    // address simply continues from it
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            ptr_q <= PTR_RST;
        end else if (!start_ev && !stop_ev) begin
            if (state_q == ST_RX && byte_end && first_q) begin
                ptr_q <= rx_q[PTR_W-1:0];       // [R5]
            end else if (o_reg_wr) begin
                ptr_q <= ptr_next(ptr_q);       // [R7] [R12]
            end else if (state_q == ST_RACK && scl_rise) begin
                ptr_q <= ptr_next(ptr_q);       // [R7] [R12]
            end
        end
    end

    // write strobe goes out one cycle after the byte ends, pointer still old
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            o_reg_wr    <= 1'b0;
            o_reg_wdata <= BYTE_RST;
        end else begin
            o_reg_wr    <= (state_q == ST_RX) && byte_end && !first_q && !start_ev && !stop_ev;  // [R6]
            o_reg_wdata <= (state_q == ST_RX && byte_end) ? rx_q : o_reg_wdata;
        end
    end

    assign o_reg_addr = ptr_q;

    // read fetch: requested at address ack or controller ack, issued a cycle
    // later so the bumped pointer is already on o_reg_addr
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            rdreq_q  <= 1'b0;
            o_reg_rd <= 1'b0;
        end else begin
            rdreq_q  <= !start_ev && !stop_ev &&
                        ((state_q == ST_ADDR && byte_end && addr_hit && rx_q[RW_BIT_POS] == RW_READ) ||  // [R8] [R11]
                         (state_q == ST_RACK && scl_rise && !sda_s));                                      // [R9]
            o_reg_rd <= rdreq_q;
        end
    end

    // read data is taken while the strobe is high; half an SCL period leaves
    // plenty of room before the byte is needed on the line
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            rbuf_q <= BYTE_RST;
        end else if (o_reg_rd) begin
            rbuf_q <= i_reg_rdata;
        end
    end

    // transmit shifter, loaded when the ack bit closes
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            tx_q <= BYTE_RST;
        end else if (scl_fall && ((state_q == ST_ACK && rw_q == RW_READ) || state_q == ST_RACK)) begin
            tx_q <= rbuf_q;
        end else if (scl_fall && state_q == ST_TX) begin
            tx_q <= {tx_q[6:0], 1'b0};
        end
    end

    // ======================================================================
    // open-drain data driver
    // ======================================================================
    assign o_sda_o = 1'b0;  // [R13] only ever pulls low

    // changes only after SCL falls, so SDA is stable while SCL is high
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            oe_n_q <= 1'b1;
        end else if (start_ev || stop_ev) begin
            oe_n_q <= 1'b1;  // [R15]
        end else if (byte_end && (state_q == ST_RX || (state_q == ST_ADDR && addr_hit))) begin
            oe_n_q <= 1'b0;  // [R6] ack
        end else if (scl_fall && ((state_q == ST_ACK && rw_q == RW_READ) || state_q == ST_RACK)) begin
            oe_n_q <= rbuf_q[7];
        end else if (scl_fall && state_q == ST_TX && !byte_end) begin
            oe_n_q <= tx_q[6];
        end else if (scl_fall) begin
            oe_n_q <= 1'b1;  // release after ack or after the last data bit
        end
    end

    assign o_sda_oe_n = oe_n_q;

    // ======================================================================
    // software reset, deferred to stop
    // ======================================================================
    // a restart leaves the arm untouched so only a true stop fires it
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            arm_q      <= 1'b0;
            o_soft_rst <= 1'b0;
        end else begin
            o_soft_rst <= stop_ev && arm_q;  // [R14]
            if (stop_ev) begin
                arm_q <= 1'b0;  // [R14] self-clears
            end else if (o_reg_wr && ptr_q[3:0] == CTRL_LOW_ADDR) begin
                arm_q <= o_reg_wdata[SRST_BIT_POS];  // [R14]
            end
        end
    end

    // ======================================================================
    // checks
    // ======================================================================
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);

    sequence s_stop_seen;
        stop_ev;
    endsequence
    sequence s_released;
        oe_n_q ##1 (state_q == ST_IDLE);
    endsequence

    stop_release_a: assert property (s_stop_seen |=> s_released)  // [R15]
        else $error("sda not released after stop");
    foreign_addr_a: assert property ((state_q == ST_ADDR) && byte_end && !addr_hit && !start_ev && !stop_ev
                                     |=> oe_n_q [*2])  // [R3]
        else $error("foreign address acknowledged");
    ack_drive_a: assert property ((state_q == ST_RX) && byte_end && !start_ev && !stop_ev
                                  |=> !oe_n_q && (state_q == ST_ACK))  // [R6]
        else $error("written byte not acknowledged");
    ptr_load_a: assert property ((state_q == ST_RX) && byte_end && first_q && !start_ev && !stop_ev
                                 |=> ptr_q == $past(rx_q[PTR_W-1:0]))  // [R5]
        else $error("register address not loaded");
    wr_bump_a: assert property (o_reg_wr && !start_ev && !stop_ev |=> ptr_q == ptr_next($past(ptr_q)))  // [R12]
        else $error("pointer did not advance after write");
    rd_fetch_a: assert property ((state_q == ST_RACK) && scl_rise && !sda_s && !start_ev && !stop_ev
                                 |=> ##1 o_reg_rd && ptr_q == ptr_next($past(ptr_q, 2)))  // [R9]
        else $error("next read byte not fetched");
    srst_stop_a: assert property (o_soft_rst |-> $past(stop_ev) && $past(arm_q))  // [R14]
        else $error("soft reset outside stop");
    restart_nosrst_a: assert property (start_ev |=> !o_soft_rst)  // [R14]
        else $error("soft reset on restart");
    sda_pulldown_a: assert property (o_sda_o == 1'b0)  // [R13]
        else $error("sda driven high");
    idle_quiet_a: assert property ((state_q == ST_IDLE) && $past(state_q == ST_IDLE) |-> oe_n_q)  // [R1]
        else $error("sda driven while idle");

endmodule

`default_nettype wire

// file: rtl/rip_pkg.sv
package rip_pkg;

    // ======================================================================
    // bus identity
    // ======================================================================
    localparam logic [6:0] TARGET_ADDR   = 7'h32;  // 0110010, fixed target address
    localparam int         RW_BIT_POS    = 0;      // direction bit inside the address byte
    localparam logic       RW_READ       = 1'b1;   // 65h read, 64h write

    // ======================================================================
    // register pointer layout
    // ======================================================================
    localparam int         PTR_W         = 5;      // 00..1F, bit 4 selects the bank
    localparam int         BANK_BIT_POS  = 4;
    localparam logic [4:0] PTR_RST       = 5'h00;
    localparam logic [3:0] CTRL_LOW_ADDR = 4'hF;   // control register at 0F or 1F
    localparam int         SRST_BIT_POS  = 0;      // software reset bit in control

    // ======================================================================
    // byte framing
    // ======================================================================
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] CNT_RST       = 4'h0;
    localparam logic [7:0] BYTE_RST      = 8'h00;

    // ======================================================================
    // timing: shortest SCL half period the sampler has to resolve
    // ======================================================================
    localparam int SYS_PERIOD_NS  = 100;
    localparam int STD_PERIOD_NS  = 10000;  // 100 kHz
    localparam int FAST_PERIOD_NS = 2500;   // 400 kHz
    localparam int FAST_HALF_CYC  = FAST_PERIOD_NS / 2 / SYS_PERIOD_NS;  // rounds down
    localparam int STD_HALF_CYC   = STD_PERIOD_NS / 2 / SYS_PERIOD_NS;

endpackage

// file: rtl/rip_sync2.sv
`timescale 1ns/1ps
`default_nettype none

// two-flop synchroniser; the first stage feeds only the second stage
module rip_sync2 #(
    parameter int             W       = 2,
    parameter logic [W-1:0]   RST_VAL = '1
) (
    input  wire logic         i_sys_clk,
    input  wire logic         i_rst_n,
    input  wire logic [W-1:0] i_d,
    output var  logic [W-1:0] o_q
);

    logic [W-1:0] meta_q;

    // idle bus lines rest high, so reset to the released level
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            meta_q <= RST_VAL;
            o_q    <= RST_VAL;
        end else begin
            meta_q <= i_d;
            o_q    <= meta_q;
        end
    end

endmodule

`default_nettype wire

// file: verification/rip_i2c_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none

// ======================================================================
// bus controller model: makes scl and framing, drives sda open-drain
// ======================================================================
module rip_i2c_ctrl_model (
    input  wire logic i_sys_clk,
    input  wire logic i_sda,
    output var  logic o_scl,
    output var  logic o_sda_oe_n
);
    // idle bus: both lines released, scl stands still between frames
    initial begin
        o_scl      = 1'b1;
        o_sda_oe_n = 1'b1;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge i_sys_clk);
    endtask

    // one bit of 800 ns: low 5 cycles, high 3, sampled late in the high phase
    // so the target's 3-4 cycle answer latency is settled by then
    task automatic bit_xfer(input logic b, output logic r);
        wait_clk(3);
        o_sda_oe_n <= b;             // only pulls low, never drives high
        wait_clk(2);
        o_scl <= 1'b1;               // the controller alone makes the clock
        wait_clk(2);
        r = i_sda;
        wait_clk(1);
        o_scl <= 1'b0;
    endtask

    // start or repeated start: sda falls while scl is high
    task automatic start_cond();
        wait_clk(3);
        o_sda_oe_n <= 1'b1;
        wait_clk(2);
        o_scl <= 1'b1;
        wait_clk(3);
        o_sda_oe_n <= 1'b0;
        wait_clk(3);
        o_scl <= 1'b0;
    endtask

    // stop: sda rises while scl is high, then the bus rests
    task automatic stop_cond();
        wait_clk(3);
        o_sda_oe_n <= 1'b0;
        wait_clk(2);
        o_scl <= 1'b1;
        wait_clk(3);
        o_sda_oe_n <= 1'b1;
        wait_clk(4);
    endtask

    // byte out msb first, then release for the target's ack
    task automatic send_byte(input logic [7:0] d, output logic ack_n);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(d[i], r);
        end
        bit_xfer(1'b1, ack_n);
    endtask

    // byte in; last answers with a nack to end the read
    task automatic recv_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(1'b1, r);
            d[i] = r;
        end
        bit_xfer(last, r);           // ack asks for more, nack ends
    endtask
endmodule

`default_nettype wire

// file: verification/rip_i2c_target_test.sv
`timescale 1ns/1ps
`default_nettype none

// ======================================================================
// self-checking bench for the serial register port
// ======================================================================
module rip_i2c_target_test;
    import rip_pkg::*;

    logic             sys_clk = 1'b0;
    logic             rst_n   = 1'b0;
    logic             scl;
    logic             ctrl_oe_n;
    logic             sda;
    logic             sda_o;
    logic             sda_oe_n;
    logic [PTR_W-1:0] reg_addr;
    logic             reg_wr;
    logic [7:0]       reg_wdata;
    logic             reg_rd;
    logic [7:0]       reg_rdata;
    logic             soft_rst;
    logic [7:0]       mem [32];
    logic [7:0]       exp_mem [32];
    logic [4:0]       exp_ptr;
    logic [7:0]       wr_cnt  = 8'h00;
    logic [7:0]       srst_cnt = 8'h00;
    logic [7:0]       none_q[$];
    int               num_errors = 0;
    int               tests_run  = 0;
    int               cyc        = 0;
    logic [15:0]      rows [4] = '{16'h05A5, 16'h0E3C, 16'h1A5A, 16'h1FC2};

    always #50 sys_clk = ~sys_clk;

    // wired-and bus with pull-up: either party may pull low
    assign sda = ctrl_oe_n & (sda_oe_n | sda_o);

    rip_i2c_ctrl_model c (
        .i_sys_clk  (sys_clk),
        .i_sda      (sda),
        .o_scl      (scl),
        .o_sda_oe_n (ctrl_oe_n)
    );

    rip_i2c_target i_dut (
        .i_sys_clk   (sys_clk),
        .i_rst_n     (rst_n),
        .i_scl       (scl),
        .i_sda       (sda),
        .o_sda_o     (sda_o),
        .o_sda_oe_n  (sda_oe_n),
        .o_reg_addr  (reg_addr),
        .o_reg_wr    (reg_wr),
        .o_reg_wdata (reg_wdata),
        .o_reg_rd    (reg_rd),
        .i_reg_rdata (reg_rdata),
        .o_soft_rst  (soft_rst)
    );

    // register file stand-in; read data follows the pointer combinationally
    assign reg_rdata = mem[reg_addr];
    initial begin
        for (int i = 0; i < 32; i++) begin
            mem[i]     = 8'(i) ^ 8'hA0;
            exp_mem[i] = 8'(i) ^ 8'hA0;
        end
    end
    always @(posedge sys_clk) begin
        if (reg_wr) begin
            mem[reg_addr] <= reg_wdata;
            wr_cnt <= wr_cnt + 8'h01;
        end
        if (soft_rst) begin
            srst_cnt <= srst_cnt + 8'h01;
        end
    end

    // hang guard: the whole run needs well under this many cycles
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            num_errors++;
            close_out();
        end
    end

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // pointer step with the bank wrap kept in bit 4
    function automatic logic [4:0] nxt(input logic [4:0] p);
        return {p[4], p[3:0] + 4'h1};
    endfunction

    task automatic close_out();
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // write frame: address, register address, data bytes; stop is optional
    task automatic wr_seq(input logic [7:0] a, input logic [7:0] d[$], input logic do_stop);
        logic ack;
        exp_ptr = a[4:0];
        c.start_cond();
        c.send_byte(8'h64, ack);
        check("write addr ack", {7'h0, ack}, 8'h00);
        c.send_byte(a, ack);
        check("reg addr ack", {7'h0, ack}, 8'h00);
        foreach (d[i]) begin
            c.send_byte(d[i], ack);
            check("data ack", {7'h0, ack}, 8'h00);
            exp_mem[exp_ptr] = d[i];
            exp_ptr = nxt(exp_ptr);
        end
        if (do_stop) begin
            c.stop_cond();
        end
    endtask

    // read frame, with the register address set first when asked
    task automatic rd_seq(input logic addressed, input logic [7:0] a, input int n);
        logic       ack;
        logic [7:0] d;
        if (addressed) begin
            wr_seq(a, none_q, 1'b0);
        end
        c.start_cond();
        c.send_byte(8'h65, ack);
        check("read addr ack", {7'h0, ack}, 8'h00);
        for (int i = 0; i < n; i++) begin
            c.recv_byte(i == n - 1, d);
            check("read data", d, exp_mem[exp_ptr]);
            exp_ptr = nxt(exp_ptr);
        end
        c.stop_cond();
        check("ptr after read", {3'h0, reg_addr}, {3'h0, exp_ptr});
    endtask

    initial begin
        logic [7:0] q[$];
        logic [7:0] d;
        logic [7:0] n_wr;
        logic       ack;
        c.wait_clk(2);
        rst_n <= 1'b1;
        c.wait_clk(2);
        check("oe_n at reset", {7'h0, sda_oe_n}, 8'h01);
        check("ptr at reset", {3'h0, reg_addr}, 8'h00);
        check("srst at reset", {7'h0, soft_rst}, 8'h00);
        // single-byte write then addressed read of two, across both banks
        foreach (rows[i]) begin
            q = {rows[i][7:0]};
            wr_seq(rows[i][15:8], q, 1'b1);
            check("stored byte", mem[rows[i][12:8]], exp_mem[rows[i][12:8]]);
            check("ptr after write", {3'h0, reg_addr}, {3'h0, exp_ptr});
            rd_seq(1'b1, rows[i][15:8], 2);
        end
        // burst through the 0F to 00 wrap, then read without an address
        q = {8'h11, 8'h22, 8'h34};
        wr_seq(8'h0E, q, 1'b1);
        check("wrap 0E", mem[5'h0E], 8'h11);
        check("wrap 0F", mem[5'h0F], 8'h22);
        check("wrap 00", mem[5'h00], 8'h34);
        rd_seq(1'b0, 8'h00, 3);
        // foreign target address is ignored, data after it is not stored
        n_wr = wr_cnt;
        c.start_cond();
        c.send_byte(8'h66, ack);
        check("foreign addr nack", {7'h0, ack}, 8'h01);
        c.send_byte(8'h05, ack);
        c.stop_cond();
        check("no foreign write", wr_cnt, n_wr);
        // reset bit survives a repeated start and fires on the stop
        q = {8'h01};
        wr_seq(8'h0F, q, 1'b0);
        c.start_cond();
        c.send_byte(8'h65, ack);
        c.recv_byte(1'b1, d);
        check("read after sr", d, exp_mem[exp_ptr]);
        exp_ptr = nxt(exp_ptr);
        check("srst held", srst_cnt, 8'h00);
        c.stop_cond();
        c.wait_clk(4);
        check("srst on stop", srst_cnt, 8'h01);
        // arm, then disarm before the stop: the stop must not fire it
        q = {8'h01};
        wr_seq(8'h1F, q, 1'b0);
        q = {8'h00};
        wr_seq(8'h1F, q, 1'b1);
        c.wait_clk(4);
        check("srst disarmed", srst_cnt, 8'h01);
        // stop in mid-byte: nothing stored, line released, next frame works
        n_wr = wr_cnt;
        wr_seq(8'h05, none_q, 1'b0);
        for (int i = 0; i < 3; i++) begin
            c.bit_xfer(1'b0, ack);
        end
        c.stop_cond();
        check("no partial write", wr_cnt, n_wr);
        check("released", {7'h0, sda_oe_n}, 8'h01);
        rd_seq(1'b1, 8'h05, 1);
        close_out();
    end
endmodule

`default_nettype wire
